// >>> include/ebarb_map.svh
// Register offsets, field positions and reset values of the external bus arbitration block.
`ifndef EBARB_MAP_SVH
`define EBARB_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define EBARB_BUS_CTRL_OFS 8'h00
`define EBARB_OP_MODE_OFS 8'h04
`define EBARB_DRAM_CTRL_OFS 8'h08
`define EBARB_STATUS_OFS 8'h0C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EBARB_HOLD_BIT 0
`define EBARB_TRACE_EN_BIT 11
`define EBARB_SYNC_EN_BIT 13
`define EBARB_MASTER_EN_BIT 0

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define EBARB_BUS_CTRL_RST 32'h0000_0000
`define EBARB_OP_MODE_RST 32'h0000_0000
`define EBARB_DRAM_CTRL_RST 32'h0000_0000
`define EBARB_CYCLE_LEN 2
`define EBARB_PHASE_LAST 2'h3

`endif

// >>> include/ebarb_pkg.sv
// Types shared by the external bus arbitration block.
package ebarb_pkg;

	// Arbitration states, one-hot.
	typedef enum logic [3:0] {
		EBARB_SLAVE = 4'h1,
		EBARB_GRANTED = 4'h2,
		EBARB_MASTER = 4'h4,
		EBARB_RELEASE = 4'h8
	} ebarb_state_e;

	// Configuration levels handed from the core domain to the link domain.
	typedef struct packed {
		logic hold;
		logic sync_en;
		logic trace_en;
		logic master_en;
		logic low_power;
	} ebarb_cfg_s;

	// Status levels handed from the link domain to the core domain.
	typedef struct packed {
		logic pending;
		logic busy_seen;
		logic grant_seen;
		logic request_on;
		logic master;
	} ebarb_stat_s;

	// Complete state of the core clock domain.
	typedef struct packed {
		logic hold;
		logic sync_en;
		logic trace_en;
		logic master_en;
		logic low_power;
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
		logic done;
		ebarb_stat_s st_s1;
		ebarb_stat_s st_s2;
		logic [7:0] addr_q;
		logic wr_q;
		logic act_q;
		logic [31:0] rdata;
	} ebarb_core_s;

	// Complete state of the link clock domain.
	typedef struct packed {
		ebarb_cfg_s cfg_s1;
		ebarb_cfg_s cfg_s2;
		logic req_s1;
		logic req_s2;
		logic grant_s1;
		logic grant_s2;
		logic grant_s3;
		logic busy_s1;
		logic busy_s2;
		logic busy_s3;
		logic ack_tgl;
		ebarb_state_e state;
		logic [3:0] cyc_cnt;
		logic cyc_act;
		logic req_pin_n;
		logic busy_o;
		logic busy_oe_n;
		logic cas_n;
		logic cas_oe_n;
		logic [1:0] phase;
		logic bclk;
		logic bclk_oe_n;
		logic bclkn;
		logic bclkn_oe_n;
		logic core_clk;
	} ebarb_link_s;

endpackage

// >>> design/ebarb_top.sv
// External bus arbitration: bus request, grant, busy line, column strobe and bus clocks.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`include "ebarb_map.svh"

module ebarb_top import ebarb_pkg::*; #(
	parameter int CYCLE_LEN = `EBARB_CYCLE_LEN
) (
	input wire logic REF_CLK, // Core clock, 40 MHz.
	input wire logic RESET_N, // Asynchronous reset, active low.
	input wire logic HSEL, // Slave select.
	input wire logic [31:0] HADDR, // Byte address.
	input wire logic [1:0] HTRANS, // Transfer type.
	input wire logic HWRITE, // Write when high.
	input wire logic [2:0] HSIZE, // Transfer size.
	input wire logic [31:0] HWDATA, // Write data.
	input wire logic HREADY, // Bus ready.
	output logic [31:0] HRDATA, // Read data.
	output logic HREADYOUT, // Slave ready.
	output logic HRESP, // Response, always OKAY.
	input wire logic EXT_ACCESS_REQ, // Core access request pulse.
	input wire logic ACCESS_IS_EXTERNAL, // Request targets the external bus.
	input wire logic STOP_WAIT, // Core in stop or wait state.
	output logic EXT_ACCESS_BUSY, // External access still pending.
	output logic EXT_ACCESS_DONE, // External bus cycle finished.
	input wire logic LINK_CLK, // External bus clock domain.
	output logic BUS_REQUEST_OUT_N, // Bus request, active low.
	input wire logic BUS_GRANT_IN_N, // Bus grant, active low.
	input wire logic BUS_BUSY_LINE_N_I, // Busy line level.
	output logic BUS_BUSY_LINE_N_O, // Busy line drive value.
	output logic BUS_BUSY_LINE_OE_N, // Busy line drive enable, low drives.
	output logic COLUMN_STROBE_N, // DRAM column strobe, active low.
	output logic COLUMN_STROBE_OE_N, // Column strobe enable, low drives.
	output logic BUS_CLOCK_OUT, // Bus clock.
	output logic BUS_CLOCK_OE_N, // Bus clock enable, low drives.
	output logic BUS_CLOCK_INVERTED, // Inverted bus clock.
	output logic BUS_CLOCK_INV_OE_N, // Inverted bus clock enable, low drives.
	output logic CORE_CLOCK_OUT // Core clock reference output.
);

	// ----------------------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------------------

	// The cycle counter is four bits wide.
	generate
		if (CYCLE_LEN < 1 || CYCLE_LEN > 15) begin : g_bad_len
			$error("CYCLE_LEN must lie between 1 and 15.");
		end
	endgenerate

	// ----------------------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------------------

	// Selects the plain or the extra-delayed synchronised pin level.
	function automatic logic sync_pick(input logic en, input logic s2, input logic s3);
		sync_pick = en ? s3 : s2;
	endfunction

	// Tests whether an address phase addresses the given register.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	// ----------------------------------------------------------------------------
	// Core clock domain
	// ----------------------------------------------------------------------------

	ebarb_core_s core_reg;
	ebarb_core_s core_next;
	ebarb_link_s link_reg;
	ebarb_link_s link_next;
	ebarb_cfg_s cfg_out;
	ebarb_stat_s stat_out;
	logic addr_take;
	logic pending_core;

	// Configuration levels leave the core domain straight from flip-flops.
	assign cfg_out = '{hold: core_reg.hold, sync_en: core_reg.sync_en, trace_en: core_reg.trace_en,
		master_en: core_reg.master_en, low_power: core_reg.low_power};

	// An address phase is taken when selected, ready and NONSEQ or SEQ.
	assign addr_take = HSEL && HREADY && HTRANS[1];

	// An access is pending until the link domain hands back its toggle.
	assign pending_core = core_reg.req_tgl != core_reg.ack_s2;

	// Register bus answers at once and never errors.
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = core_reg.rdata;
	assign EXT_ACCESS_BUSY = pending_core;
	assign EXT_ACCESS_DONE = core_reg.done;

	// Next state of the core domain: register writes, reads and access handshake.
	always_comb begin
		core_next = core_reg;
		core_next.low_power = STOP_WAIT;
		core_next.ack_s1 = link_reg.ack_tgl;
		core_next.ack_s2 = core_reg.ack_s1;
		core_next.st_s1 = stat_out;
		core_next.st_s2 = core_reg.st_s1;
		// A finished cycle shows as one pulse per returned toggle.
		core_next.done = core_reg.ack_s2 != core_reg.ack_seen;
		core_next.ack_seen = core_reg.ack_s2;
		// Only an external access starts a request; internal ones never do.
		if (EXT_ACCESS_REQ && ACCESS_IS_EXTERNAL && !pending_core) begin
			core_next.req_tgl = !core_reg.req_tgl;
		end
		// Data phase of a write updates the addressed register.
		if (core_reg.act_q && core_reg.wr_q) begin
			if (hit(core_reg.addr_q, `EBARB_BUS_CTRL_OFS)) begin
				core_next.hold = HWDATA[`EBARB_HOLD_BIT];
			end else if (hit(core_reg.addr_q, `EBARB_OP_MODE_OFS)) begin
				core_next.sync_en = HWDATA[`EBARB_SYNC_EN_BIT];
				core_next.trace_en = HWDATA[`EBARB_TRACE_EN_BIT];
			end else if (hit(core_reg.addr_q, `EBARB_DRAM_CTRL_OFS)) begin
				core_next.master_en = HWDATA[`EBARB_MASTER_EN_BIT];
			end
		end
		// Address phase is remembered for the data phase.
		core_next.act_q = addr_take;
		if (addr_take) begin
			core_next.addr_q = HADDR[7:0];
			core_next.wr_q = HWRITE;
		end
		// Read data is built from next values so a write just before is seen.
		core_next.rdata = 32'h0000_0000;
		if (addr_take && !HWRITE) begin
			if (hit(HADDR[7:0], `EBARB_BUS_CTRL_OFS)) begin
				core_next.rdata[`EBARB_HOLD_BIT] = core_next.hold;
			end else if (hit(HADDR[7:0], `EBARB_OP_MODE_OFS)) begin
				core_next.rdata[`EBARB_SYNC_EN_BIT] = core_next.sync_en;
				core_next.rdata[`EBARB_TRACE_EN_BIT] = core_next.trace_en;
			end else if (hit(HADDR[7:0], `EBARB_DRAM_CTRL_OFS)) begin
				core_next.rdata[`EBARB_MASTER_EN_BIT] = core_next.master_en;
			end else if (hit(HADDR[7:0], `EBARB_STATUS_OFS)) begin
				core_next.rdata[4:0] = core_reg.st_s2;
			end
		end
	end

	// Core domain registers.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			core_reg <= '0;
			core_reg.hold <= 1'(`EBARB_BUS_CTRL_RST >> `EBARB_HOLD_BIT);
			core_reg.sync_en <= 1'(`EBARB_OP_MODE_RST >> `EBARB_SYNC_EN_BIT);
			core_reg.trace_en <= 1'(`EBARB_OP_MODE_RST >> `EBARB_TRACE_EN_BIT);
			core_reg.master_en <= 1'(`EBARB_DRAM_CTRL_RST >> `EBARB_MASTER_EN_BIT);
		end else begin
			core_reg <= core_next;
		end
	end

	// ----------------------------------------------------------------------------
	// Link clock domain
	// ----------------------------------------------------------------------------

	logic grant;
	logic busy;
	logic pending_link;
	logic is_master;
	logic lp;
	logic clk_on;
	logic [1:0] phase_nx;

	// Pin levels after synchronisers, optionally one stage later.
	assign grant = sync_pick(link_reg.cfg_s2.sync_en, !link_reg.grant_s2, !link_reg.grant_s3);
	assign busy = sync_pick(link_reg.cfg_s2.sync_en, !link_reg.busy_s2, !link_reg.busy_s3);
	assign pending_link = link_reg.req_s2 != link_reg.ack_tgl;
	assign is_master = link_reg.state == EBARB_MASTER;
	assign lp = link_reg.cfg_s2.low_power;

	// Status levels come from link domain flip-flops; pending and master pass through compare logic first.
	assign stat_out = '{pending: link_reg.req_s2 != link_reg.ack_tgl, busy_seen: !link_reg.busy_s2,
		grant_seen: !link_reg.grant_s2, request_on: !link_reg.req_pin_n, master: is_master};

	// Next state of the link domain: arbitration, request, strobes and clocks.
	always_comb begin
		link_next = link_reg;
		link_next.cfg_s1 = cfg_out;
		link_next.cfg_s2 = link_reg.cfg_s1;
		link_next.req_s1 = core_reg.req_tgl;
		link_next.req_s2 = link_reg.req_s1;
		link_next.grant_s1 = BUS_GRANT_IN_N;
		link_next.grant_s2 = link_reg.grant_s1;
		link_next.grant_s3 = link_reg.grant_s2;
		link_next.busy_s1 = BUS_BUSY_LINE_N_I;
		link_next.busy_s2 = link_reg.busy_s1;
		link_next.busy_s3 = link_reg.busy_s2;
		clk_on = 1'b0;
		phase_nx = link_reg.phase + 2'h1;

		// Bus request follows need or hold; in stop/wait a set hold bit keeps its level, a clear one drops it.
		if (lp) begin
			if (!link_reg.cfg_s2.hold) begin
				link_next.req_pin_n = 1'b1;
			end
		end else begin
			link_next.req_pin_n = !(pending_link || link_reg.cfg_s2.hold);
		end

		// Arbitration; grant-driven moves are frozen in stop or wait.
		case (link_reg.state)
			EBARB_SLAVE: begin
				link_next.busy_oe_n = 1'b1;
				if (!lp && grant) begin
					link_next.state = EBARB_GRANTED;
				end
			end
			EBARB_GRANTED: begin
				if (!lp) begin
					if (!grant) begin
						link_next.state = EBARB_SLAVE;
					end else if (!busy) begin
						// Take the bus only once the line is free, then drive it.
						link_next.state = EBARB_MASTER;
						link_next.busy_o = 1'b0;
						link_next.busy_oe_n = 1'b0;
					end
				end
			end
			EBARB_MASTER: begin
				// Busy stays driven while parked, whatever the request level.
				link_next.busy_o = 1'b0;
				link_next.busy_oe_n = 1'b0;
				if (link_reg.cyc_act) begin
					if (link_reg.cyc_cnt == 4'h0) begin
						link_next.cyc_act = 1'b0;
						link_next.ack_tgl = !link_reg.ack_tgl;
					end else begin
						link_next.cyc_cnt = link_reg.cyc_cnt - 4'h1;
					end
				end else if (!lp && !grant) begin
					// Grant gone and no cycle running: release the line.
					link_next.state = EBARB_RELEASE;
					link_next.busy_o = 1'b1;
				end else if (pending_link && grant) begin
					link_next.cyc_act = 1'b1;
					link_next.cyc_cnt = 4'(CYCLE_LEN - 1);
				end
			end
			EBARB_RELEASE: begin
				// One cycle of active high drive, then the pull-up holds it.
				link_next.busy_oe_n = 1'b1;
				link_next.state = EBARB_SLAVE;
			end
			default: begin
				link_next.state = EBARB_SLAVE;
				link_next.busy_oe_n = 1'b1;
			end
		endcase

		// Column strobe: low during a cycle as master, high or floating otherwise.
		link_next.cas_n = !link_next.cyc_act;
		link_next.cas_oe_n = !(link_next.state == EBARB_MASTER || link_reg.cfg_s2.master_en);

		// Four-phase divider: bus clock is a quarter period ahead of core clock.
		link_next.phase = phase_nx;
		link_next.core_clk = phase_nx[1];
		clk_on = link_next.state == EBARB_MASTER && link_reg.cfg_s2.trace_en;
		link_next.bclk = clk_on ? (phase_nx[1] ^ phase_nx[0]) : link_reg.bclk;
		link_next.bclk_oe_n = !clk_on;
		link_next.bclkn = !link_next.bclk;
		link_next.bclkn_oe_n = link_next.state != EBARB_MASTER;
	end

	// Link domain registers; reset leaves request off and the state slave.
	always_ff @(posedge LINK_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			link_reg <= '0;
			link_reg.grant_s1 <= 1'b1;
			link_reg.grant_s2 <= 1'b1;
			link_reg.grant_s3 <= 1'b1;
			link_reg.busy_s1 <= 1'b1;
			link_reg.busy_s2 <= 1'b1;
			link_reg.busy_s3 <= 1'b1;
			link_reg.state <= EBARB_SLAVE;
			link_reg.req_pin_n <= 1'b1;
			link_reg.busy_o <= 1'b1;
			link_reg.busy_oe_n <= 1'b1;
			link_reg.cas_n <= 1'b1;
			link_reg.cas_oe_n <= 1'b1;
			link_reg.bclk_oe_n <= 1'b1;
			link_reg.bclkn <= 1'b1;
			link_reg.bclkn_oe_n <= 1'b1;
		end else begin
			link_reg <= link_next;
		end
	end

	// ----------------------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------------------

	// All link pins come straight from link domain flip-flops.
	assign BUS_REQUEST_OUT_N = link_reg.req_pin_n;
	assign BUS_BUSY_LINE_N_O = link_reg.busy_o;
	assign BUS_BUSY_LINE_OE_N = link_reg.busy_oe_n;
	assign COLUMN_STROBE_N = link_reg.cas_n;
	assign COLUMN_STROBE_OE_N = link_reg.cas_oe_n;
	assign BUS_CLOCK_OUT = link_reg.bclk;
	assign BUS_CLOCK_OE_N = link_reg.bclk_oe_n;
	assign BUS_CLOCK_INVERTED = link_reg.bclkn;
	assign BUS_CLOCK_INV_OE_N = link_reg.bclkn_oe_n;
	assign CORE_CLOCK_OUT = link_reg.core_clk;

endmodule

// >>> bench/ebarb_top_asserts.sv
// Port-level checks of the external bus arbitration block.
`timescale 1ns/100ps

module ebarb_top_asserts #(
	parameter int CYCLE_LEN = 2
) (
	input wire logic REF_CLK, // Core clock.
	input wire logic RESET_N, // Reset, active low.
	input wire logic EXT_ACCESS_REQ, // Access pulse.
	input wire logic ACCESS_IS_EXTERNAL, // External target.
	input wire logic EXT_ACCESS_BUSY, // Access pending.
	input wire logic EXT_ACCESS_DONE, // Access finished.
	input wire logic LINK_CLK, // Link clock.
	input wire logic BUS_REQUEST_OUT_N, // Bus request.
	input wire logic BUS_GRANT_IN_N, // Bus grant.
	input wire logic BUS_BUSY_LINE_N_I, // Busy level.
	input wire logic BUS_BUSY_LINE_N_O, // Busy drive value.
	input wire logic BUS_BUSY_LINE_OE_N, // Busy enable.
	input wire logic COLUMN_STROBE_N, // Column strobe.
	input wire logic COLUMN_STROBE_OE_N, // Strobe enable.
	input wire logic BUS_CLOCK_OUT, // Bus clock.
	input wire logic BUS_CLOCK_OE_N, // Bus clock enable.
	input wire logic BUS_CLOCK_INVERTED, // Inverted bus clock.
	input wire logic BUS_CLOCK_INV_OE_N, // Inverted enable.
	input wire logic CORE_CLOCK_OUT // Core clock out.
);
	int unsigned low_cnt;

	// Counts the link cycles the column strobe has been low.
	always_ff @(posedge LINK_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= COLUMN_STROBE_N ? 0 : low_cnt + 1;
		end
	end

	// Master drives busy low; a release drives it high first.
	sequence master_s;
		!BUS_BUSY_LINE_OE_N && !BUS_BUSY_LINE_N_O;
	endsequence
	sequence drive_high_s;
		!BUS_BUSY_LINE_OE_N && BUS_BUSY_LINE_N_O;
	endsequence

	reset_idle_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		$rose(RESET_N) |-> BUS_REQUEST_OUT_N && BUS_BUSY_LINE_OE_N && BUS_CLOCK_OE_N) else $error("idle after reset");
	take_over_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		$fell(BUS_BUSY_LINE_OE_N) |-> $past(BUS_BUSY_LINE_N_I, 2) && !$past(BUS_GRANT_IN_N, 2))
		else $error("mastership taken early");
	busy_release_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		drive_high_s |=> BUS_BUSY_LINE_OE_N) else $error("busy high drive too long");
	busy_float_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		$rose(BUS_BUSY_LINE_OE_N) |-> $past(BUS_BUSY_LINE_N_O)) else $error("busy released low");
	park_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		(!BUS_GRANT_IN_N)[*5] ##0 master_s |=> master_s) else $error("parked master let go");
	strobe_master_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		!COLUMN_STROBE_N && !COLUMN_STROBE_OE_N |-> master_s) else $error("strobe as slave");
	strobe_len_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		$rose(COLUMN_STROBE_N) |-> low_cnt == CYCLE_LEN) else $error("strobe length");
	clk_master_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		!BUS_CLOCK_OE_N |-> !BUS_CLOCK_INV_OE_N && !BUS_BUSY_LINE_OE_N) else $error("bus clock as slave");
	clk_inv_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		!BUS_CLOCK_INV_OE_N |-> BUS_CLOCK_INVERTED != BUS_CLOCK_OUT) else $error("inverted clock");
	lead_quarter_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
		!BUS_CLOCK_OE_N |=> CORE_CLOCK_OUT == $past(BUS_CLOCK_OUT)) else $error("bus clock lead");
	ext_only_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		$rose(EXT_ACCESS_BUSY) |-> $past(EXT_ACCESS_REQ && ACCESS_IS_EXTERNAL)) else $error("internal access");
	done_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		EXT_ACCESS_DONE |-> !EXT_ACCESS_BUSY ##1 !EXT_ACCESS_DONE) else $error("done pulse");
endmodule

bind ebarb_top ebarb_top_asserts #(.CYCLE_LEN(CYCLE_LEN)) ebarb_top_asserts_inst (.REF_CLK, .RESET_N,
	.EXT_ACCESS_REQ, .ACCESS_IS_EXTERNAL, .EXT_ACCESS_BUSY, .EXT_ACCESS_DONE, .LINK_CLK, .BUS_REQUEST_OUT_N,
	.BUS_GRANT_IN_N, .BUS_BUSY_LINE_N_I, .BUS_BUSY_LINE_N_O, .BUS_BUSY_LINE_OE_N, .COLUMN_STROBE_N,
	.COLUMN_STROBE_OE_N, .BUS_CLOCK_OUT, .BUS_CLOCK_OE_N, .BUS_CLOCK_INVERTED, .BUS_CLOCK_INV_OE_N,
	.CORE_CLOCK_OUT);

// >>> bench/ebarb_arb_model.sv
// Outside arbiter plus a second master sharing the pulled-up busy line.
`timescale 1ns/100ps

module ebarb_arb_model (
	input wire logic link_clk, // Link clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic req_n, // Device bus request.
	input wire logic dev_o, // Device busy drive value.
	input wire logic dev_oe_n, // Device busy enable, low drives.
	input wire logic other_req, // Second master wants the bus.
	input wire logic [3:0] lat, // Grant latency in link cycles.
	output logic grant_n, // Grant to the device.
	output wire logic busy_n // Resolved busy line.
);
	logic oth_drv;
	logic [3:0] cnt;

	// The device drive wins, then the second master, else the pull-up.
	assign busy_n = !dev_oe_n ? dev_o : (oth_drv ? 1'h0 : 1'h1);

	// Grants after a latency; the second master waits for a free line.
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			grant_n <= 1'h1;
			oth_drv <= 1'h0;
			cnt <= 4'h0;
		end else if (other_req) begin
			grant_n <= 1'h1;
			cnt <= 4'h0;
			if (busy_n && dev_oe_n) begin
				oth_drv <= 1'h1;
			end
		end else begin
			oth_drv <= 1'h0;
			if (!req_n && grant_n) begin
				cnt <= cnt + 4'h1;
				if (cnt >= lat) begin
					grant_n <= 1'h0;
				end
			end
		end
	end
endmodule

// >>> bench/external_bus_arbitration_bench.sv
// Self-checking testbench of the external bus arbitration block.
`timescale 1ns/100ps
`include "ebarb_map.svh"

module external_bus_arbitration_bench;
	logic REF_CLK = 1'h0;
	logic LINK_CLK = 1'h0;
	logic RESET_N, HSEL, HWRITE, HREADY, EXT_ACCESS_REQ, ACCESS_IS_EXTERNAL, STOP_WAIT, other_req, hi_seen;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [3:0] lat;
	logic HREADYOUT, HRESP, EXT_ACCESS_BUSY, EXT_ACCESS_DONE, BUS_REQUEST_OUT_N, BUS_GRANT_IN_N, last_bclk;
	logic BUS_BUSY_LINE_N_O, BUS_BUSY_LINE_OE_N, COLUMN_STROBE_N, COLUMN_STROBE_OE_N, BUS_CLOCK_OUT;
	logic BUS_CLOCK_OE_N, BUS_CLOCK_INVERTED, BUS_CLOCK_INV_OE_N, CORE_CLOCK_OUT;
	wire BUS_BUSY_LINE_N_I;
	logic [31:0] regs [4];
	int failures = 0;
	int n_checks = 0;
	int tog = 0;

	// The single slave's ready is the bus ready.
	assign HREADY = HREADYOUT;

	// Clocks of unrelated phase.
	always #12.5 REF_CLK = ~REF_CLK;
	always #40 LINK_CLK = ~LINK_CLK;

	ebarb_top #(.CYCLE_LEN(1)) ebarb_top_inst (.REF_CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
		.HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .EXT_ACCESS_REQ, .ACCESS_IS_EXTERNAL, .STOP_WAIT,
		.EXT_ACCESS_BUSY, .EXT_ACCESS_DONE, .LINK_CLK, .BUS_REQUEST_OUT_N, .BUS_GRANT_IN_N, .BUS_BUSY_LINE_N_I,
		.BUS_BUSY_LINE_N_O, .BUS_BUSY_LINE_OE_N, .COLUMN_STROBE_N, .COLUMN_STROBE_OE_N, .BUS_CLOCK_OUT,
		.BUS_CLOCK_OE_N, .BUS_CLOCK_INVERTED, .BUS_CLOCK_INV_OE_N, .CORE_CLOCK_OUT);
	ebarb_arb_model ebarb_arb_model_inst (.link_clk(LINK_CLK), .rst_n(RESET_N), .req_n(BUS_REQUEST_OUT_N),
		.dev_o(BUS_BUSY_LINE_N_O), .dev_oe_n(BUS_BUSY_LINE_OE_N), .other_req, .lat, .grant_n(BUS_GRANT_IN_N),
		.busy_n(BUS_BUSY_LINE_N_I));

	// Notes a high drive of the busy line and counts bus clock edges.
	always @(posedge LINK_CLK) begin
		if (!BUS_BUSY_LINE_OE_N && BUS_BUSY_LINE_N_O) hi_seen = 1'h1;
		if (BUS_CLOCK_OUT !== last_bclk) tog++;
		last_bclk = BUS_CLOCK_OUT;
	end

	task automatic end_of_test();
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic met(input int w);
		case (w)
			0: return EXT_ACCESS_DONE === 1'h1;
			1: return BUS_BUSY_LINE_OE_N === 1'h1;
			2: return BUS_REQUEST_OUT_N === 1'h0;
			3: return BUS_REQUEST_OUT_N === 1'h1;
			default: return COLUMN_STROBE_OE_N === 1'h0;
		endcase
	endfunction

	// Bounded wait on a condition, sampled at each core clock edge.
	task automatic wait_for(input int w);
		int k;
		k = 0;
		do begin
			@(posedge REF_CLK);
			k++;
		end while (!met(w) && k < 2000);
		if (!met(w)) begin
			failures++;
			end_of_test();
		end
	endtask

	// One single AHB-Lite word transfer; read data lands in rd.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		HSEL <= 1'h1;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HADDR <= {24'h0, a};
		for (int p = 0; p < 2; p++) begin
			k = 0;
			do begin
				@(posedge REF_CLK);
				k++;
			end while (HREADYOUT !== 1'h1 && k < 16);
			if (HREADYOUT !== 1'h1) begin
				failures++;
				end_of_test();
			end
			if (p == 0) begin
				HSEL <= 1'h0;
				HTRANS <= 2'h0;
				HWDATA <= d;
			end
		end
		rd = HRDATA;
	endtask

	function automatic logic [31:0] mask(input logic [7:0] a);
		case (a)
			`EBARB_BUS_CTRL_OFS, `EBARB_DRAM_CTRL_OFS: return 32'h1;
			`EBARB_OP_MODE_OFS: return 32'h2800;
			default: return 32'h0;
		endcase
	endfunction

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'h1, a, d);
		if (a[7:4] == 4'h0) regs[a[3:2]] = d & mask(a);
	endtask

	task automatic reg_rd(input logic [7:0] a);
		ahb(1'h0, a, 32'h0);
		chk(rd, (a[7:4] == 4'h0) ? regs[a[3:2]] : 32'h0);
	endtask

	task automatic access(input logic ext);
		EXT_ACCESS_REQ <= 1'h1;
		ACCESS_IS_EXTERNAL <= ext;
		@(posedge REF_CLK);
		EXT_ACCESS_REQ <= 1'h0;
	endtask

	// Main sequence.
	initial begin
		{RESET_N, HSEL, HWRITE, EXT_ACCESS_REQ, ACCESS_IS_EXTERNAL, STOP_WAIT, other_req} = 7'h0;
		{HADDR, HWDATA, HTRANS} = 66'h0;
		HSIZE = 3'h2;
		hi_seen = 1'h0;
		last_bclk = 1'h0;
		void'($urandom(86));
		lat = 4'h1 + 4'($urandom % 6);
		regs = '{default: 32'h0};
		repeat (10) @(posedge REF_CLK);
		RESET_N <= 1'h1;
		@(posedge REF_CLK);
		for (int i = 4; i >= 0; i--) begin
			reg_rd(8'(i * 4));
			reg_wr(8'(i * 4), $urandom & 32'hFFFF_FFFE);
			reg_rd(8'(i * 4));
		end
		reg_wr(`EBARB_OP_MODE_OFS, 32'h2800);
		access(1'h1);
		wait_for(2);
		chk(32'(EXT_ACCESS_BUSY), 32'h1);
		wait_for(0);
		wait_for(3);
		chk(32'({BUS_BUSY_LINE_OE_N, BUS_BUSY_LINE_N_O}), 32'h0);
		repeat (4) @(posedge REF_CLK);
		ahb(1'h0, `EBARB_STATUS_OFS, 32'h0);
		chk(rd, 32'h0000_000D);
		@(posedge LINK_CLK);
		#1 tog = 0;
		repeat (16) @(posedge LINK_CLK);
		#1 chk(32'(tog), 32'h8);
		@(posedge REF_CLK);
		access(1'h0);
		@(posedge REF_CLK);
		chk(32'({EXT_ACCESS_BUSY, BUS_REQUEST_OUT_N}), 32'h1);
		hi_seen = 1'h0;
		other_req <= 1'h1;
		wait_for(1);
		chk(32'(hi_seen), 32'h1);
		chk(32'({BUS_CLOCK_OE_N, BUS_CLOCK_INV_OE_N, COLUMN_STROBE_OE_N}), 32'h7);
		reg_wr(`EBARB_DRAM_CTRL_OFS, 32'h1);
		wait_for(4);
		chk(32'(COLUMN_STROBE_N), 32'h1);
		reg_wr(`EBARB_DRAM_CTRL_OFS, 32'h0);
		reg_wr(`EBARB_OP_MODE_OFS, 32'h0);
		lat = 4'h1 + 4'($urandom % 6);
		access(1'h1);
		wait_for(2);
		repeat (60) @(posedge REF_CLK);
		chk(32'({BUS_BUSY_LINE_OE_N, EXT_ACCESS_BUSY}), 32'h3);
		other_req <= 1'h0;
		wait_for(0);
		chk(32'(BUS_CLOCK_OE_N), 32'h1);
		reg_wr(`EBARB_BUS_CTRL_OFS, 32'h1);
		wait_for(2);
		STOP_WAIT <= 1'h1;
		repeat (8) @(posedge REF_CLK);
		other_req <= 1'h1;
		repeat (40) @(posedge REF_CLK);
		chk(32'({BUS_REQUEST_OUT_N, BUS_BUSY_LINE_OE_N}), 32'h0);
		reg_wr(`EBARB_BUS_CTRL_OFS, 32'h0);
		wait_for(3);
		STOP_WAIT <= 1'h0;
		wait_for(1);
		other_req <= 1'h0;
		reg_wr(`EBARB_BUS_CTRL_OFS, 32'h1);
		wait_for(2);
		RESET_N <= 1'h0;
		regs = '{default: 32'h0};
		repeat (10) @(posedge REF_CLK);
		chk(32'({BUS_REQUEST_OUT_N, BUS_BUSY_LINE_OE_N}), 32'h3);
		RESET_N <= 1'h1;
		@(posedge REF_CLK);
		reg_rd(`EBARB_BUS_CTRL_OFS);
		end_of_test();
	end
endmodule
